// ### rtl/rfq_defs.vh
/*
  Constants for the receive-port frame qualifier: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by bare name from the rtl files that need it.
*/
// Notes on behaviour
// - Packing field 00 keeps ten-bit pixels, 10 uses upper eight, 11 lower eight bits.
// - Truncate-on-parity set (reset value) cuts a frame on parity error; clear forwards it.
// - Truncate-on-line-size set cuts a frame when line size changes.
// - Truncate-on-frame-size set cuts on line count change; forwarding resumes after threshold.
// - Line polarity 1 means line flag low during a line, 0 means high.
// - Frame polarity 1 means frame flag low during a frame, 0 means high.
// - Qualify-discard enable set drops packets while qualification is false.
// - Height check enabled: line count change drops qualification until threshold met.
// - Line size check enabled: line size change drops qualification until threshold met.
// - Parity mode 1: parity error clears qualification until threshold met again.
// - Watchdog enabled with a nonzero threshold: no frame end within two frame periods drops qualification.
// - Registers exist per port; host picks the copy via the port select register.
`ifndef RFQ_DEFS_VH
`define RFQ_DEFS_VH

`define RFQ_PORT_SELECT_ADDR 8'h4c
`define RFQ_FORMAT_CFG_ADDR 8'h7c
`define RFQ_QUALIFY_CTL_ADDR 8'h7d

`define RFQ_FORMAT_CFG_RST 8'h20
`define RFQ_QUALIFY_CTL_RST 8'h00

`define RFQ_PACK_HI 7
`define RFQ_PACK_LO 6
`define RFQ_TRUNC_PARITY 5
`define RFQ_TRUNC_LSIZE 4
`define RFQ_TRUNC_FSIZE 3
`define RFQ_LINE_POL 1
`define RFQ_FRAME_POL 0

`define RFQ_DISCARD_EN 7
`define RFQ_HEIGHT_CHECK 5
`define RFQ_WIDTH_CHECK 4
`define RFQ_PARITY_MODE 3
`define RFQ_WDOG_DIS 2
`define RFQ_THRESH_HI 1
`define RFQ_THRESH_LO 0

`define RFQ_PACK_NORMAL 2'b00
`define RFQ_PACK_UPPER 2'b10
`define RFQ_PACK_LOWER 2'b11

`define RFQ_WDOG_PERIODS 2

`endif

// ### rtl/rfq_skid_buffer.v
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module rfq_skid_buffer #(
  parameter WIDTH = 12
) (
  input wire mclk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_r [0:1];
  reg wr_ptr_r;
  reg rd_ptr_r;
  reg [1:0] count_r;
  wire push;
  wire pop;

  // Honest flags from the occupancy count
  assign in_ready = (count_r != 2'd2);
  assign out_valid = (count_r != 2'd0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage written without reset
  always @(posedge mclk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  // Pointers and count
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        count_r <= count_r + 2'd1;
      else if (pop && !push)
        count_r <= count_r - 2'd1;
    end
  end

endmodule

// ### rtl/rfq_frame_qualifier.v
/*
  Receive-port frame qualifier: per-port configuration registers reached
  through a port select register, raw flag polarity, ten-bit packing,
  forward qualification and packet discard, with a two-entry output buffer.
  Assumes pixel inputs are synchronous to mclk and that parity, lock and
  frame flags of each port come from that port's own link receiver.
*/
`timescale 1ns/1ps
`include "rfq_defs.vh"
module rfq_frame_qualifier #(
  parameter PORTS = 2,
  parameter PORT_BITS = 1,
  parameter WDOG_BITS = 24
) (
  input wire mclk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [PORTS-1:0] rx_lock,
  input wire [PORTS-1:0] parity_err,
  input wire [PORTS-1:0] line_active_flag,
  input wire [PORTS-1:0] frame_active_flag,
  input wire [PORTS*10-1:0] pix_data,
  input wire [PORTS-1:0] pix_valid,
  output wire [PORTS-1:0] pix_ready,
  output wire [PORTS-1:0] fwd_qualified,
  output wire [PORTS*12-1:0] out_data,
  output wire [PORTS-1:0] out_valid,
  input wire [PORTS-1:0] out_ready
);

  reg [7:0] port_select_r;
  reg [7:0] rdata_nxt;
  integer i;

  // Port select decode used by writes and reads
  function sel_hit;
    input [7:0] psel;
    input integer idx;
    begin
      sel_hit = psel[idx];
    end
  endfunction

  // Port select register; bit n reaches port n's copy
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      port_select_r <= 8'h00;
    else if (reg_wr && reg_addr == `RFQ_PORT_SELECT_ADDR)
      port_select_r <= reg_wdata;
  end

  wire [PORTS*8-1:0] fmt_cfg_all;
  wire [PORTS*8-1:0] qual_ctl_all;

  // Read mux: lowest selected port answers
  // With no select bit set no copy is reached and per-port reads give zero
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_addr == `RFQ_PORT_SELECT_ADDR)
      rdata_nxt = port_select_r;
    for (i = PORTS - 1; i >= 0; i = i - 1)
    begin
      if (sel_hit(port_select_r, i))
      begin
        if (reg_addr == `RFQ_FORMAT_CFG_ADDR)
          rdata_nxt = fmt_cfg_all[i*8 +: 8];
        else if (reg_addr == `RFQ_QUALIFY_CTL_ADDR)
          rdata_nxt = qual_ctl_all[i*8 +: 8];
      end
    end
  end

  // Read data registered on a read strobe
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1)
    begin : port_g
      reg [7:0] fmt_cfg_r;
      reg [7:0] qual_ctl_r;
      reg line_d_r;
      reg frame_d_r;
      reg [15:0] line_len_r;
      reg [15:0] last_len_r;
      reg [15:0] line_cnt_r;
      reg [15:0] last_cnt_r;
      reg len_known_r;
      reg cnt_known_r;
      reg frame_bad_r;
      reg [1:0] good_cnt_r;
      reg qual_r;
      reg trunc_r;
      reg [WDOG_BITS-1:0] period_r;
      reg [WDOG_BITS-1:0] since_end_r;
      reg period_known_r;
      wire wr_here;
      wire line_on;
      wire frame_on;
      wire line_end;
      wire frame_start;
      wire frame_end;
      wire size_change;
      wire height_change;
      wire perr;
      wire qual_drop;
      wire wdog_fire;
      wire [1:0] thresh;
      wire [9:0] pix;
      wire [11:0] packed_w;
      wire drop_pix;

      assign fmt_cfg_all[g*8 +: 8] = fmt_cfg_r;
      assign qual_ctl_all[g*8 +: 8] = qual_ctl_r;
      assign wr_here = reg_wr && sel_hit(port_select_r, g);
      assign thresh = qual_ctl_r[`RFQ_THRESH_HI:`RFQ_THRESH_LO];

      // Configuration registers of this port
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          fmt_cfg_r <= `RFQ_FORMAT_CFG_RST;
          qual_ctl_r <= `RFQ_QUALIFY_CTL_RST;
        end
        else
        begin
          if (wr_here && reg_addr == `RFQ_FORMAT_CFG_ADDR)
            fmt_cfg_r <= reg_wdata;
          if (wr_here && reg_addr == `RFQ_QUALIFY_CTL_ADDR)
            qual_ctl_r <= reg_wdata;
        end
      end

      // Flag polarity: inverted flags are active low
      assign line_on = line_active_flag[g] ^ fmt_cfg_r[`RFQ_LINE_POL];
      assign frame_on = frame_active_flag[g] ^ fmt_cfg_r[`RFQ_FRAME_POL];
      assign line_end = line_d_r && !line_on;
      assign frame_start = frame_on && !frame_d_r;
      assign frame_end = frame_d_r && !frame_on;
      assign perr = parity_err[g];
      assign size_change = line_end && len_known_r && (line_len_r != last_len_r);
      assign height_change = frame_end && cnt_known_r && (line_cnt_r != last_cnt_r);
      // Watchdog: time since the last frame end against twice the last period;
      // a missing end restarts the count, so the drop repeats while frames stay away
      assign wdog_fire = !qual_ctl_r[`RFQ_WDOG_DIS] && (thresh != 2'd0) && period_known_r &&
        (since_end_r >= period_r * `RFQ_WDOG_PERIODS);
      // Events that clear the qualification until the threshold is met
      assign qual_drop = (qual_ctl_r[`RFQ_HEIGHT_CHECK] && height_change) ||
        (qual_ctl_r[`RFQ_WIDTH_CHECK] && size_change) ||
        (qual_ctl_r[`RFQ_PARITY_MODE] && perr) ||
        wdog_fire || !rx_lock[g];

      // Line size, line count and frame period measurement
      // Dropped words still count toward line size, so a discard alone
      // never looks like a change in line size
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          line_d_r <= 1'b0;
          frame_d_r <= 1'b0;
          line_len_r <= 16'h0000;
          last_len_r <= 16'h0000;
          line_cnt_r <= 16'h0000;
          last_cnt_r <= 16'h0000;
          len_known_r <= 1'b0;
          cnt_known_r <= 1'b0;
          period_r <= {WDOG_BITS{1'b0}};
          since_end_r <= {WDOG_BITS{1'b0}};
          period_known_r <= 1'b0;
        end
        else
        begin
          line_d_r <= line_on;
          frame_d_r <= frame_on;
          if (line_on && pix_valid[g] && pix_ready[g])
            line_len_r <= line_len_r + 16'h0001;
          else if (line_end)
            line_len_r <= 16'h0000;
          if (line_end)
          begin
            last_len_r <= line_len_r;
            len_known_r <= 1'b1;
            line_cnt_r <= line_cnt_r + 16'h0001;
          end
          if (frame_end)
          begin
            last_cnt_r <= line_cnt_r;
            cnt_known_r <= 1'b1;
            line_cnt_r <= 16'h0000;
            period_r <= since_end_r;
            period_known_r <= 1'b1;
            since_end_r <= {WDOG_BITS{1'b0}};
          end
          else if (wdog_fire)
            since_end_r <= {WDOG_BITS{1'b0}};
          else if (since_end_r != {WDOG_BITS{1'b1}})
            since_end_r <= since_end_r + {{(WDOG_BITS-1){1'b0}}, 1'b1};
        end
      end

      // Qualification: count consecutive valid frames toward the threshold
      // Drop events win over counting, so a fault in the closing cycle
      // of a frame keeps that frame from counting as valid
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          frame_bad_r <= 1'b0;
          good_cnt_r <= 2'd0;
          qual_r <= 1'b0;
        end
        else if (qual_drop)
        begin
          qual_r <= 1'b0;
          good_cnt_r <= 2'd0;
          frame_bad_r <= 1'b1;
        end
        else if (thresh == 2'd0)
        begin
          qual_r <= 1'b1;
          good_cnt_r <= 2'd0;
          frame_bad_r <= 1'b0;
        end
        else if (frame_start)
          frame_bad_r <= perr;
        else if (frame_end)
        begin
          frame_bad_r <= 1'b0;
          if (!frame_bad_r && !perr && !qual_r)
          begin
            if (good_cnt_r + 2'd1 >= thresh)
              qual_r <= 1'b1;
            good_cnt_r <= good_cnt_r + 2'd1;
          end
          else if (frame_bad_r)
            good_cnt_r <= 2'd0;
        end
        else if (perr)
          frame_bad_r <= 1'b1;
      end

      // Per-cycle qualification: parity mode 0 masks only the error cycle
      assign fwd_qualified[g] = qual_r && !(perr && !qual_ctl_r[`RFQ_PARITY_MODE]);

      // Truncation latch: rest of the frame is dropped after a fault
      // A fault on the frame-start cycle belongs to the new frame, so set wins
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
          trunc_r <= 1'b0;
        else if ((fmt_cfg_r[`RFQ_TRUNC_PARITY] && perr) ||
          (fmt_cfg_r[`RFQ_TRUNC_LSIZE] && size_change) ||
          (fmt_cfg_r[`RFQ_TRUNC_FSIZE] && height_change))
          trunc_r <= 1'b1;
        else if (frame_start)
          trunc_r <= 1'b0;
      end

      // Ten-bit packing selection
      // Eight-bit modes zero-fill the upper pixel bits; the matching data
      // type code is set by software outside this block
      assign pix = pix_data[g*10 +: 10];
      assign packed_w = (fmt_cfg_r[`RFQ_PACK_HI:`RFQ_PACK_LO] == `RFQ_PACK_UPPER) ?
        {line_on, frame_on, 2'b00, pix[9:2]} :
        (fmt_cfg_r[`RFQ_PACK_HI:`RFQ_PACK_LO] == `RFQ_PACK_LOWER) ?
        {line_on, frame_on, 2'b00, pix[7:0]} :
        {line_on, frame_on, pix};
      // Frame-size truncation stays until qualification returns
      assign drop_pix = trunc_r || (fmt_cfg_r[`RFQ_TRUNC_PARITY] && perr) ||
        (qual_ctl_r[`RFQ_DISCARD_EN] && !fwd_qualified[g]) ||
        (fmt_cfg_r[`RFQ_TRUNC_FSIZE] && cnt_known_r && !qual_r && thresh != 2'd0);

      // Two-entry buffer keeps accepted words through a receiver stall
      rfq_skid_buffer #(
        .WIDTH(12)
      ) u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(pix_valid[g] && !drop_pix),
        .in_ready(pix_ready[g]),
        .in_data(packed_w),
        .out_valid(out_valid[g]),
        .out_ready(out_ready[g]),
        .out_data(out_data[g*12 +: 12])
      );
    end
  endgenerate

endmodule

// ### verification/rfq_props.sv
/*
  Port checker for the frame qualifier, port 0.
  Assumes it is bound to rfq_frame_qualifier.
*/
`timescale 1ns/1ps
module rfq_props #(
  parameter PORTS = 2
) (
  input wire mclk,
  input wire rst,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire [PORTS-1:0] rx_lock,
  input wire [PORTS-1:0] parity_err,
  input wire [PORTS-1:0] pix_valid,
  input wire [PORTS-1:0] pix_ready,
  input wire [PORTS-1:0] fwd_qualified,
  input wire [PORTS*12-1:0] out_data,
  input wire [PORTS-1:0] out_valid,
  input wire [PORTS-1:0] out_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Lock loss and parity errors pull qualification down
  lock_drop_a: assert property (!rx_lock[0] |=> !fwd_qualified[0])
    else $error("qualified without lock");
  parity_drop_a: assert property (parity_err[0] |-> ##[0:1] !fwd_qualified[0])
    else $error("parity error left qualification up");
  // Buffer handshake
  word_hold_a: assert property (out_valid[0] && !out_ready[0] |=> out_valid[0] && $stable(out_data[11:0]))
    else $error("stalled word changed");
  idle_empty_a: assert property (!pix_valid[0] && !out_valid[0] |=> !out_valid[0])
    else $error("word from nowhere");
  empty_ready_a: assert property (!out_valid[0] |-> pix_ready[0])
    else $error("empty buffer refused");
  full_stays_a: assert property (!pix_ready[0] && !out_ready[0] |=> !pix_ready[0] && out_valid[0])
    else $error("full buffer lost a word");
  // Register read data
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h4c && reg_addr != 8'h7c && reg_addr != 8'h7d
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

// ### verification/rfq_sensor_model.sv
/*
  Remote video source for one receive port.
  Assumes frame() is called while idle, after a clock edge.
*/
`timescale 1ns/1ps
module rfq_sensor_model (
  input wire mclk,
  input wire ready,
  input wire lpol,
  input wire fpol,
  output reg lock = 0,
  output reg perr = 0,
  output reg line_f = 0,
  output reg frame_f = 0,
  output reg [9:0] data = 10'h000,
  output reg valid = 0
);
  // Set when a word waited out its bound without being taken
  bit stuck = 0;
  // Frame of nl lines by nw words; word el carries a parity pulse
  task frame(input int nl, input int nw, input int el);
    int l, w, k;
    bit r;
    begin
      frame_f = fpol;
      line_f = lpol;
      @(posedge mclk) #1 frame_f = !fpol;
      for (l = 0; l < nl; l++)
      begin
        @(posedge mclk) #1 line_f = !lpol;
        for (w = 0; w < nw; w++)
        begin
          data = 10'($urandom);
          valid = 1;
          perr = (l * nw + w == el);
          for (k = 0; k < 200; k++)
          begin
            r = ready;
            @(posedge mclk) #1 perr = 0;
            if (r)
              break;
          end
          if (k == 200)
            stuck = 1;
        end
        valid = 0;
        data = ~data;
        line_f = lpol;
      end
      @(posedge mclk) #1 frame_f = fpol;
      repeat (40) @(posedge mclk);
      #1;
    end
  endtask
endmodule

// ### verification/rx_port_frame_qualifier_bench.sv
/*
  Self-checking bench for the frame qualifier.
  Assumes two source models and a queue scoreboard on port 0.
*/
`timescale 1ns/1ps
module rx_port_frame_qualifier_bench;
  reg mclk = 0;
  reg rst = 1;
  reg reg_wr = 0;
  reg reg_rd = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg [1:0] out_ready = 2'h3;
  reg [1:0] lpol = 2'h0;
  reg [1:0] fpol = 2'h0;
  reg [1:0] pm = 2'h0;
  wire [7:0] reg_rdata;
  wire [1:0] rx_lock, parity_err, lf, ff, pix_valid, pix_ready, fwd_qualified, out_valid;
  wire [19:0] pix_data;
  wire [23:0] out_data;
  int error_cnt = 0, check_count = 0, n_in = 0, n_out = 0, i, f;
  bit strict = 1;
  logic [11:0] q[$];
  // Clock and random output stalls
  always #50 mclk = ~mclk;
  always @(posedge mclk) out_ready <= #1 2'($urandom);
  rfq_frame_qualifier i_dut (
    .mclk(mclk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .rx_lock(rx_lock),
    .parity_err(parity_err),
    .line_active_flag(lf),
    .frame_active_flag(ff),
    .pix_data(pix_data),
    .pix_valid(pix_valid),
    .pix_ready(pix_ready),
    .fwd_qualified(fwd_qualified),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );
  for (genvar g = 0; g < 2; g++)
  begin : gs
    rfq_sensor_model i_s (
      .mclk(mclk),
      .ready(pix_ready[g]),
      .lpol(lpol[g]),
      .fpol(fpol[g]),
      .lock(rx_lock[g]),
      .perr(parity_err[g]),
      .line_f(lf[g]),
      .frame_f(ff[g]),
      .data(pix_data[g*10+:10]),
      .valid(pix_valid[g])
    );
  end
  // Scoreboard: predicted word per accepted pixel, compared at each pop while strict is set
  always @(posedge mclk)
  begin
    if (pix_valid[0] && pix_ready[0])
    begin
      n_in++;
      q.push_back({2'b11, pm == 2'b00 ? pix_data[9:0] : {2'b00, pm[0] ? pix_data[7:0] : pix_data[9:2]}});
    end
    if (out_valid[0] && out_ready[0])
    begin
      n_out++;
      if (strict)
        chk(out_data[11:0], q.pop_front());
    end
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task w(input int n);
  begin
    repeat (n) @(posedge mclk);
    #1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge mclk) #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge mclk) #1 reg_wr = 0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge mclk) #1 reg_addr = a;
    reg_rd = 1;
    @(posedge mclk) #1 reg_rd = 0;
    chk({4'h0, reg_rdata}, {4'h0, e});
  end
  endtask
  task qf(input bit e);
    chk({11'h000, fwd_qualified[0]}, {11'h000, e});
  endtask
  task fr(input int nl, input int nw, input int el);
  begin
    gs[0].i_s.frame(nl, nw, el);
    if (gs[0].i_s.stuck)
    begin
      error_cnt++;
      test_done;
    end
  end
  endtask
  task test_done;
  begin
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Hang guard
  initial
  begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    test_done;
  end
  // Main sequence
  initial
  begin
    i = $urandom(32'haccc);
    w(2);
    rst = 0;
    rd(8'h4c, 8'h00);
    wr(8'h4c, 8'h01);
    rd(8'h7c, 8'h20);
    rd(8'h7d, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h4c, 8'h01);
    wr(8'h7d, 8'h81);
    wr(8'h4c, 8'h02);
    wr(8'h7d, 8'h06);
    rd(8'h7d, 8'h06);
    wr(8'h4c, 8'h01);
    rd(8'h7d, 8'h81);
    wr(8'h7d, 8'h00);
    $display("register test done");
    for (i = 0; i < 3; i++)
    begin
      pm = (i == 0) ? 2'b00 : {1'b1, i[0]};
      wr(8'h7c, {pm, 4'h0, i[1:0]});
      if (pm != 2'b00)
        wr(8'h70, 8'h2a); // data type register lies outside this block
      lpol[0] = i[1];
      fpol[0] = i[0];
      fr(3, 5, -1);
      chk(12'(q.size()), 12'h000);
    end
    fr(3, 5, 7);
    chk(12'(q.size()), 12'h000);
    $display("format test done");
    pm = 2'b00;
    lpol[0] = 0;
    fpol[0] = 0;
    wr(8'h7c, 8'h20);
    strict = 0;
    n_in = 0;
    n_out = 0;
    fr(3, 5, 2);
    chk({11'h000, n_out < n_in}, 12'h001);
    chk(12'(n_out), 12'h002);
    wr(8'h7c, 8'h10);
    n_out = 0;
    fr(3, 4, -1);
    chk(12'(n_out), 12'h004);
    wr(8'h7c, 8'h00);
    $display("truncation test done");
    for (i = 0; i < 4; i++)
    begin
      wr(8'h7d, 8'h04 | 8'(i));
      gs[0].i_s.lock = 0;
      w(3);
      qf(0);
      gs[0].i_s.lock = 1;
      w(3);
      qf(i == 0);
      for (f = 1; f <= i; f++)
      begin
        fr(3, 4, -1);
        qf(f == i);
      end
    end
    $display("threshold test done");
    for (i = 0; i < 2; i++)
    begin
      wr(8'h7d, i ? 8'h0e : 8'h06);
      fr(3, 4, -1);
      fr(3, 4, -1);
      qf(1);
      fr(3, 4, 5);
      qf(!i);
      fr(3, 4, -1);
      qf(!i);
      fr(3, 4, -1);
      qf(1);
    end
    $display("parity mode test done");
    for (i = 0; i < 2; i++)
    begin
      wr(8'h7d, i ? 8'h15 : 8'h25);
      fr(3, 4, -1);
      fr(3, 4, -1);
      qf(1);
      fr(i ? 3 : 2, i ? 3 : 4, -1);
      qf(0);
      if (i == 0)
      begin
        wr(8'h7c, 8'h08);
        n_out = 0;
        fr(2, 4, -1);
        chk(12'(n_out), 12'h000);
        qf(1);
        wr(8'h7c, 8'h00);
      end
    end
    for (i = 0; i < 2; i++)
    begin
      wr(8'h7d, i ? 8'h05 : 8'h01);
      fr(3, 4, -1);
      fr(3, 4, -1);
      qf(1);
      w(300);
      qf(i);
    end
    $display("size and watchdog test done");
    wr(8'h7d, 8'h81);
    gs[0].i_s.lock = 0;
    n_out = 0;
    fr(3, 4, -1);
    chk(12'(n_out), 12'h000);
    wr(8'h7d, 8'h01);
    q.delete();
    strict = 1;
    fr(3, 4, -1);
    chk(12'(q.size()), 12'h000);
    $display("discard test done");
    test_done;
  end
endmodule
bind rfq_frame_qualifier rfq_props #(.PORTS(PORTS)) i_chk (
  .mclk(mclk),
  .rst(rst),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .rx_lock(rx_lock),
  .parity_err(parity_err),
  .pix_valid(pix_valid),
  .pix_ready(pix_ready),
  .fwd_qualified(fwd_qualified),
  .out_data(out_data),
  .out_valid(out_valid),
  .out_ready(out_ready)
);
